// ---- hw/oscst_pkg.sv ----
// oscst_pkg: addresses, reset values, field positions and thresholds
package oscst_pkg;
	localparam logic [15:0] ADDR_MAIN_OSC_CTRL = 16'hFFA2;
	localparam logic [15:0] ADDR_SETTLE_STATUS = 16'hFFA3;
	localparam logic [15:0] ADDR_SETTLE_SELECT = 16'hFFA4;
	localparam logic [7:0] RST_MAIN_OSC_CTRL = 8'h80;
	localparam logic [7:0] RST_SETTLE_STATUS = 8'h00;
	localparam logic [2:0] RST_SETTLE_SELECT = 3'h5;
	localparam int HALT_BIT = 7;
	localparam int SEL_W = 3;
	localparam int FLAG_N = 5;
	localparam int CNT_W = 17;
	localparam logic [SEL_W-1:0] SEL_2P11 = 3'h1;
	localparam logic [SEL_W-1:0] SEL_2P13 = 3'h2;
	localparam logic [SEL_W-1:0] SEL_2P14 = 3'h3;
	localparam logic [SEL_W-1:0] SEL_2P15 = 3'h4;
	localparam logic [SEL_W-1:0] SEL_2P16 = 3'h5;
	localparam int EXP_2P11 = 11;
	localparam int EXP_2P13 = 13;
	localparam int EXP_2P14 = 14;
	localparam int EXP_2P15 = 15;
	localparam int EXP_2P16 = 16;
endpackage

// ---- hw/oscst_top.sv ----
// oscst_top: x1 oscillation stabilization counter, status and select registers
// Overview of operation
// - status clears on reset release, stop instruction, or halt bit written one
// - flags for 2^11,2^13,2^14,2^15,2^16 set in order and stay set
// - status byte at ffa3, reset zero, bits 7..5 zero, bit4=2^11 .. bit0=2^16
// - status is read only; bit and byte reads, writes ignored
// - cpu on x1 is held after stop release until chosen wait elapses
// - select codes 1..5 choose 2^11,2^13,2^14,2^15,2^16; others prohibited
// - select at ffa4, byte writes only, reset 5, bits 7..3 zero
// - counter stops at selected threshold, so later flags stay clear
// - only real x1 edges count; time before oscillation starts is excluded
// - counter also runs while cpu uses another clock
// - halt bit 7 of ffa2 stops x1 when one, reset value one
`timescale 1ns/1ns
`default_nettype none
module oscst_top #(
	parameter int CNT_W = oscst_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_x1_clk,
	input wire logic i_stop_exec,
	input wire logic i_stop_release,
	input wire logic i_cpu_on_x1,
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic i_bit_wr,
	input wire logic [2:0] i_bit_idx,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rbit,
	output logic o_x1_osc_halt,
	output logic o_cpu_hold
);
	typedef struct packed {
		logic x1_s1;
		logic x1_s2;
		logic x1_prev;
		logic [CNT_W-1:0] cnt;
		logic [oscst_pkg::SEL_W-1:0] sel;
		logic halt;
		logic stop_mode;
		logic hold;
		logic [7:0] rdata;
		logic rbit;
	} oscst_state_s;

	oscst_state_s st_ff;
	oscst_state_s nxt_st;

	// counter must reach the longest threshold
	if (CNT_W < oscst_pkg::EXP_2P16 + 1) begin : g_cnt_w_check
		$error("oscst_top: CNT_W too small for 2^16 count");
	end

	// selected wait in x1 cycles
	function automatic logic [CNT_W-1:0] sel_limit(input logic [oscst_pkg::SEL_W-1:0] s);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		case (s)
			oscst_pkg::SEL_2P11: sel_limit = one << oscst_pkg::EXP_2P11;
			oscst_pkg::SEL_2P13: sel_limit = one << oscst_pkg::EXP_2P13;
			oscst_pkg::SEL_2P14: sel_limit = one << oscst_pkg::EXP_2P14;
			oscst_pkg::SEL_2P15: sel_limit = one << oscst_pkg::EXP_2P15;
			default: sel_limit = one << oscst_pkg::EXP_2P16;
		endcase
	endfunction

	// threshold flags, bit4 shortest to bit0 longest
	function automatic logic [oscst_pkg::FLAG_N-1:0] flags_of(input logic [CNT_W-1:0] c);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		flags_of[4] = c >= (one << oscst_pkg::EXP_2P11);
		flags_of[3] = c >= (one << oscst_pkg::EXP_2P13);
		flags_of[2] = c >= (one << oscst_pkg::EXP_2P14);
		flags_of[1] = c >= (one << oscst_pkg::EXP_2P15);
		flags_of[0] = c >= (one << oscst_pkg::EXP_2P16);
	endfunction

	function automatic logic [7:0] status_byte(input logic [CNT_W-1:0] c);
		status_byte = {3'h0, flags_of(c)};
	endfunction

	logic [CNT_W-1:0] limit;
	logic x1_rise;
	logic at_limit;
	logic halt_wr;
	logic [7:0] rd_byte;

	always_comb begin
		nxt_st = st_ff;
		limit = sel_limit(st_ff.sel);
		at_limit = st_ff.cnt >= limit;
		x1_rise = st_ff.x1_s2 && !st_ff.x1_prev;
		halt_wr = 1'b0;
		rd_byte = 8'h00;
		nxt_st.x1_s1 = i_x1_clk;
		nxt_st.x1_s2 = st_ff.x1_s1;
		nxt_st.x1_prev = st_ff.x1_s2;
		// halt register, byte or bit write
		if (i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL) begin
			if (i_wr) begin
				nxt_st.halt = i_wdata[oscst_pkg::HALT_BIT];
				halt_wr = 1'b1;
			end else if (i_bit_wr && i_bit_idx == 3'(oscst_pkg::HALT_BIT)) begin
				nxt_st.halt = i_wdata[0];
				halt_wr = 1'b1;
			end
		end
		// select takes byte writes only, bit writes dropped
		if (i_wr && i_addr == oscst_pkg::ADDR_SETTLE_SELECT) begin
			nxt_st.sel = i_wdata[oscst_pkg::SEL_W-1:0];
		end
		if (i_stop_exec) begin
			nxt_st.stop_mode = 1'b1;
		end else if (i_stop_release) begin
			nxt_st.stop_mode = 1'b0;
		end
		// count x1 edges only while oscillating, any cpu clock
		if (x1_rise && !st_ff.halt && !st_ff.stop_mode && !at_limit) begin
			nxt_st.cnt = st_ff.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		// clear on stop or halt written one
		if (i_stop_exec || (halt_wr && nxt_st.halt) || st_ff.halt) begin
			nxt_st.cnt = '0;
		end
		// hold cpu on x1 after stop release until wait done
		if (i_stop_release && st_ff.stop_mode && i_cpu_on_x1) begin
			nxt_st.hold = 1'b1;
		end else if (st_ff.hold && at_limit) begin
			nxt_st.hold = 1'b0;
		end
		// register read, status bits 7..5 zero
		case (i_addr)
			oscst_pkg::ADDR_MAIN_OSC_CTRL: rd_byte = {st_ff.halt, 7'h00};
			oscst_pkg::ADDR_SETTLE_STATUS: rd_byte = status_byte(st_ff.cnt);
			oscst_pkg::ADDR_SETTLE_SELECT: rd_byte = {5'h00, st_ff.sel};
			default: rd_byte = 8'h00;
		endcase
		if (i_rd) begin
			nxt_st.rdata = rd_byte;
			nxt_st.rbit = rd_byte[i_bit_idx];
		end
		if (i_reset) begin
			nxt_st = '0;
			nxt_st.sel = oscst_pkg::RST_SETTLE_SELECT;
			nxt_st.halt = oscst_pkg::RST_MAIN_OSC_CTRL[oscst_pkg::HALT_BIT];
			nxt_st.cnt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		st_ff <= nxt_st;
	end

	assign o_rdata = st_ff.rdata;
	assign o_rbit = st_ff.rbit;
	assign o_x1_osc_halt = st_ff.halt;
	assign o_cpu_hold = st_ff.hold;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	logic [oscst_pkg::FLAG_N-1:0] flags;
	logic [7:0] status_view;
	logic [7:0] sel_view;
	assign flags = flags_of(st_ff.cnt);
	assign status_view = {3'h0, flags};
	assign sel_view = {5'h00, st_ff.sel};

	AST_CLEAR_ON_STOP: assert property (i_stop_exec |=> flags == '0)
		else $error("status not cleared after stop");
	AST_CLEAR_ON_HALT: assert property (st_ff.halt |-> st_ff.cnt == '0)
		else $error("count nonzero while x1 halted");
	AST_FLAG_ORDER: assert property (flags[0] |-> flags[1] && flags[2] && flags[3] && flags[4])
		else $error("flags not thermometer coded");
	AST_FLAG_STICKY: assert property (flags[4] && !i_stop_exec && !halt_wr |=> flags[4])
		else $error("flag dropped without clear");
	AST_STATUS_HIGH_ZERO: assert property (i_rd && i_addr == oscst_pkg::ADDR_SETTLE_STATUS
		|=> o_rdata[7:5] == 3'h0 && o_rdata[4:0] == $past(flags))
		else $error("status read wrong");
	AST_STATUS_RO: assert property (i_wr && i_addr == oscst_pkg::ADDR_SETTLE_STATUS
		&& !st_ff.halt && !i_stop_exec |=> st_ff.cnt >= $past(st_ff.cnt))
		else $error("status changed by write");
	AST_SEL_BYTE_ONLY: assert property (i_bit_wr && !i_wr |=> st_ff.sel == $past(st_ff.sel))
		else $error("select changed by bit write");
	AST_SEL_READ: assert property (i_rd && i_addr == oscst_pkg::ADDR_SETTLE_SELECT
		|=> o_rdata == {5'h00, $past(st_ff.sel)})
		else $error("select read wrong");
	AST_CNT_CAP: assert property (at_limit |=> st_ff.cnt <= $past(st_ff.cnt))
		else $error("count passed selected limit");
	AST_HOLD_SET: assert property (i_stop_release && st_ff.stop_mode && i_cpu_on_x1
		|=> o_cpu_hold)
		else $error("cpu not held after stop release");
	AST_HOLD_END: assert property (o_cpu_hold && at_limit && !i_stop_release |=> !o_cpu_hold)
		else $error("hold not released at wait end");
	AST_EDGE_ONLY: assert property (st_ff.cnt != $past(st_ff.cnt) && st_ff.cnt != '0
		|-> $past(x1_rise))
		else $error("count moved without x1 edge");
	AST_HALT_WR: assert property (i_wr && i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL
		|=> o_x1_osc_halt == $past(i_wdata[oscst_pkg::HALT_BIT]))
		else $error("halt bit not written");

	// flag chain and stickiness, one pair for each of flags 0..3
	for (genvar gi = 0; gi < oscst_pkg::FLAG_N - 1; gi++) begin : g_flag_chk
		AST_FLAG_CHAIN: assert property (flags[gi] |-> flags[gi+1])
			else $error("flag set before shorter threshold");
		AST_FLAG_HOLD: assert property (flags[gi] && !i_stop_exec && !halt_wr
			|=> flags[gi])
			else $error("flag dropped without clear");
	end

	// reset values, checked one cycle after reset is high
	AST_RESET_VALUES: assert property (@(posedge i_clk) disable iff (1'b0) i_reset
		|=> st_ff.sel == oscst_pkg::RST_SETTLE_SELECT && st_ff.cnt == '0 && !o_cpu_hold
		&& o_x1_osc_halt == oscst_pkg::RST_MAIN_OSC_CTRL[oscst_pkg::HALT_BIT])
		else $error("reset values wrong");
	AST_CLEAR_ON_HALT_WR: assert property (i_wr && i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL
		&& i_wdata[oscst_pkg::HALT_BIT] |=> st_ff.cnt == '0)
		else $error("count not cleared by halt write");
	AST_STOP_NO_COUNT: assert property (st_ff.stop_mode
		|-> st_ff.cnt == '0)
		else $error("count moved in stop mode");

	// register bus checks
	AST_STATUS_BIT: assert property (i_rd && i_addr == oscst_pkg::ADDR_SETTLE_STATUS
		|=> o_rbit == $past(status_view[i_bit_idx]))
		else $error("status bit read wrong");
	AST_SEL_BIT: assert property (i_rd && i_addr == oscst_pkg::ADDR_SETTLE_SELECT
		|=> o_rbit == $past(sel_view[i_bit_idx]))
		else $error("select bit read wrong");
	AST_RD_HOLDS: assert property (!i_rd
		|=> $stable(o_rdata) && $stable(o_rbit))
		else $error("read data changed without read");
	AST_UNMAPPED: assert property (i_rd && i_addr != oscst_pkg::ADDR_MAIN_OSC_CTRL
		&& i_addr != oscst_pkg::ADDR_SETTLE_STATUS && i_addr != oscst_pkg::ADDR_SETTLE_SELECT
		|=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_STATUS_WR_IGNORED: assert property (i_wr && i_addr == oscst_pkg::ADDR_SETTLE_STATUS
		|=> $stable(st_ff.sel) && $stable(st_ff.halt))
		else $error("status write changed a register");
	AST_SEL_WRITE: assert property (i_wr && i_addr == oscst_pkg::ADDR_SETTLE_SELECT
		|=> st_ff.sel == $past(i_wdata[oscst_pkg::SEL_W-1:0]))
		else $error("select write lost");
	AST_SEL_STABLE: assert property (!(i_wr && i_addr == oscst_pkg::ADDR_SETTLE_SELECT)
		|=> $stable(st_ff.sel))
		else $error("select changed without write");
	AST_HALT_BIT_WR: assert property (i_bit_wr && !i_wr && i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL
		&& i_bit_idx == 3'(oscst_pkg::HALT_BIT) |=> o_x1_osc_halt == $past(i_wdata[0]))
		else $error("halt bit write lost");
	AST_HALT_STABLE: assert property (!((i_wr || i_bit_wr) && i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL)
		|=> $stable(o_x1_osc_halt))
		else $error("halt changed without write");
	AST_HALT_READ: assert property (i_rd && i_addr == oscst_pkg::ADDR_MAIN_OSC_CTRL
		|=> o_rdata == {$past(o_x1_osc_halt), 7'h00})
		else $error("halt read wrong");
	AST_FLAGS_ZERO_HALTED: assert property (o_x1_osc_halt
		|-> flags == '0)
		else $error("flags set while x1 halted");

	// counter checks
	AST_CNT_STEP: assert property (st_ff.cnt == '0 || st_ff.cnt == $past(st_ff.cnt)
		|| st_ff.cnt == $past(st_ff.cnt) + CNT_W'(1))
		else $error("count jumped");
	AST_SATURATE: assert property (at_limit && !i_stop_exec && !halt_wr && !st_ff.halt
		|=> st_ff.cnt == $past(st_ff.cnt))
		else $error("count moved at limit");
	AST_COUNT_RUN: assert property (x1_rise && !st_ff.halt && !st_ff.stop_mode && !at_limit
		&& !i_stop_exec && !halt_wr |=> st_ff.cnt == $past(st_ff.cnt) + CNT_W'(1))
		else $error("x1 edge not counted");

	// stop and hold checks
	AST_STOP_MODE_SET: assert property (i_stop_exec
		|=> st_ff.stop_mode)
		else $error("stop mode not entered");
	AST_HOLD_NEEDS_X1: assert property (!o_cpu_hold
		&& !(i_stop_release && st_ff.stop_mode && i_cpu_on_x1) |=> !o_cpu_hold)
		else $error("cpu held without stop release on x1");
	AST_HOLD_WAIT: assert property ($fell(o_cpu_hold) && !$past(i_reset)
		|-> st_ff.cnt >= sel_limit(st_ff.sel))
		else $error("hold released before wait");

	COV_FIRST_FLAG: cover property (!flags[4] ##1 flags[4]);
	COV_ALL_FLAGS: cover property (!flags[0] ##1 flags[0]);
	COV_HOLD_DONE: cover property (o_cpu_hold ##1 !o_cpu_hold);
	COV_STOP_CLEAR: cover property (flags[4] && i_stop_exec);
	COV_HALT_BIT_WR: cover property (halt_wr && i_bit_wr);
endmodule
`default_nettype wire

// ---- bench/oscst_tb.sv ----
// tb: register level tests of the x1 stabilization counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
	logic i_clk = 1'b0, i_reset = 1'b1, i_x1_clk = 1'b0, i_stop_exec = 1'b0;
	logic i_stop_release = 1'b0, i_cpu_on_x1 = 1'b0, i_rd = 1'b0, i_wr = 1'b0, i_bit_wr = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [2:0] i_bit_idx = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_rbit, o_x1_osc_halt, o_cpu_hold;
	int error_cnt = 0;
	int compares = 0;
	int n;
	oscst_top oscst_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_x1_clk(i_x1_clk),
		.i_stop_exec(i_stop_exec), .i_stop_release(i_stop_release), .i_cpu_on_x1(i_cpu_on_x1),
		.i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_bit_wr(i_bit_wr), .i_bit_idx(i_bit_idx),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .o_rbit(o_rbit), .o_x1_osc_halt(o_x1_osc_halt),
		.o_cpu_hold(o_cpu_hold));
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	// x1 at about 6.7 MHz
	initial begin
		forever #75 i_x1_clk = ~i_x1_clk;
	end
	task automatic rd(input logic [15:0] a, input logic [2:0] b, input logic [7:0] e);
		@(negedge i_clk);
		i_addr = a;
		i_bit_idx = b;
		i_rd = 1'b1;
		@(negedge i_clk);
		i_rd = 1'b0;
		`CHK(o_rdata, e)
		`CHK(o_rbit, e[b])
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bw, input logic [2:0] b);
		@(negedge i_clk);
		i_addr = a;
		i_wdata = d;
		i_bit_idx = b;
		i_wr = ~bw;
		i_bit_wr = bw;
		@(negedge i_clk);
		i_wr = 1'b0;
		i_bit_wr = 1'b0;
	endtask
	task automatic waitx(input int k);
		repeat (k) @(posedge i_x1_clk);
		repeat (6) @(negedge i_clk);
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#(80000 * 50);
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		@(negedge i_clk) i_reset = 1'b0;
		rd(16'hFFA3, 3'h4, 8'h00);
		rd(16'hFFA4, 3'h0, 8'h05);
		rd(16'hFFA2, 3'h7, 8'h80);
		wr(16'hFFA4, 8'hFF, 1'b0, 3'h0);
		wr(16'hFFA4, 8'h00, 1'b1, 3'h2);
		rd(16'hFFA4, 3'h2, 8'h07);
		wr(16'hFFA4, 8'h01, 1'b0, 3'h0);
		wr(16'hFFA3, 8'hFF, 1'b0, 3'h0);
		rd(16'hFFA3, 3'h0, 8'h00);
		rd(16'hFFA5, 3'h0, 8'h00);
		wr(16'hFFA2, 8'h00, 1'b0, 3'h0);
		waitx(1000);
		`CHK(o_x1_osc_halt, 1'b0)
		rd(16'hFFA3, 3'h4, 8'h00);
		waitx(1100);
		rd(16'hFFA3, 3'h4, 8'h10);
		wr(16'hFFA2, 8'h01, 1'b1, 3'h7);
		`CHK(o_x1_osc_halt, 1'b1)
		rd(16'hFFA3, 3'h4, 8'h00);
		wr(16'hFFA4, 8'h02, 1'b0, 3'h0);
		wr(16'hFFA2, 8'h00, 1'b0, 3'h0);
		waitx(8250);
		rd(16'hFFA3, 3'h3, 8'h18);
		wr(16'hFFA4, 8'h01, 1'b0, 3'h0);
		@(negedge i_clk) i_stop_exec = 1'b1;
		@(negedge i_clk) i_stop_exec = 1'b0;
		rd(16'hFFA3, 3'h3, 8'h00);
		i_cpu_on_x1 = 1'b1;
		@(negedge i_clk) i_stop_release = 1'b1;
		@(negedge i_clk) i_stop_release = 1'b0;
		`CHK(o_cpu_hold, 1'b1)
		n = 0;
		while (o_cpu_hold === 1'b1 && n < 20000) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(n > 6000 && n < 7000, 1'b1)
		rd(16'hFFA3, 3'h4, 8'h10);
		@(negedge i_clk) i_reset = 1'b1;
		@(negedge i_clk) i_reset = 1'b0;
		rd(16'hFFA4, 3'h0, 8'h05);
		rd(16'hFFA3, 3'h4, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
